// ==== common/clk_ctrl_pkg.sv ====
package clk_ctrl_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] OSC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] CLK_DIV_ADDR = 8'h04;
    localparam logic [7:0] PLL_FBD_ADDR = 8'h08;

    // oscillator control fields
    localparam int CUR_SRC_LSB = 12;
    localparam int NEW_SRC_LSB = 8;
    localparam int CFG_LOCK_BIT = 7;
    localparam int PIN_LOCK_BIT = 6;
    localparam int PLL_LOCK_BIT = 5;
    localparam int CF_BIT = 3;
    localparam int SW_REQ_BIT = 0;

    // clock divisor fields
    localparam int RECOVER_BIT = 15;
    localparam int DOZE_LSB = 12;
    localparam int RATIO_EN_BIT = 11;
    localparam int FRC_DIV_LSB = 8;
    localparam int POST_LSB = 6;
    localparam int PRE_LSB = 0;

    // reset values
    localparam logic [2:0] FRC_DIV_RST = 3'h1;
    localparam logic [8:0] FBD_RST = 9'h030;
    localparam logic [2:0] ERASED_SRC = 3'h7;

    // source codes
    localparam logic [2:0] SRC_FRC = 3'h0;
    localparam logic [2:0] SRC_FRC_PLL = 3'h1;
    localparam logic [2:0] SRC_PRI = 3'h2;
    localparam logic [2:0] SRC_PRI_PLL = 3'h3;
    localparam logic [2:0] SRC_BACKUP = 3'h4;
    localparam logic [2:0] SRC_LOW_POWER_INTERNAL_OSC = 3'h5;
    localparam logic [2:0] SRC_FRC_DIV16 = 3'h6;
    localparam logic [2:0] SRC_FRC_DIVN = 3'h7;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int PLL_START_NS = 2000;
    localparam int PLL_START_CYC = (PLL_START_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int HANDOVER_NS = 200;
    localparam int HANDOVER_CYC = (HANDOVER_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        SW_IDLE = 4'b0001,
        SW_GATE = 4'b0010,
        SW_MOVE = 4'b0100,
        SW_UNGATE = 4'b1000
    } sw_state_t;
endpackage

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
    import clk_ctrl_pkg::*;
    logic clk_i, rst_i, sys_rst_i, cyc, stb, we, erased_i, unlock_i, irq_i;
    logic fsafe, cfail, ofail, plock, ack, gate_low, pll_en, gate, cy, per, fen;
    logic [7:0] adr;
    logic [31:0] dat, q32;
    logic [2:0] isrc, cur;
    logic [1:0] pm, pmo;
    logic [9:0] mult;
    logic [5:0] pre;
    logic [3:0] post;
    logic [15:0] q, d, f;
    logic [31:0] seed;
    int failures, compares, c1, c2, c3;
    clk_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .sys_rst_i(sys_rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(q32), .wb_ack_o(ack),
        .initial_source_cfg_i(isrc), .primary_mode_cfg_i(pm),
        .failsafe_switch_cfg_i(fsafe), .erased_i(erased_i),
        .unlock_i(unlock_i), .irq_i(irq_i), .clock_fail_i(cfail),
        .fast_osc_fail_i(ofail), .pll_locked_i(plock),
        .current_source_sel_o(cur), .primary_mode_o(pmo),
        .pll_enable_o(pll_en), .sys_clk_gate_o(gate), .cy_en_o(cy),
        .per_en_o(per), .frc_div_en_o(fen), .pll_mult_o(mult),
        .pll_pre_o(pre), .pll_post_o(post));
    // ****************************************
    // clock, watchdog, gate monitor
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        close_out();
    end
    always @(posedge clk_i) begin
        if (rst_i === 1'b1) gate_low <= 1'b0;
        else if (gate === 1'b0) gate_low <= 1'b1;
    end
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction
    function automatic logic [15:0] n2(input logic [1:0] p);
        return 16'(2 * (p + 2'h0) + 2);
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one classic cycle, optional unlock pulse first
    task automatic bus(input bit u, input bit w, input logic [7:0] a,
                       input logic [15:0] v);
        if (u) begin
            unlock_i <= 1'b1;
            @(posedge clk_i);
            unlock_i <= 1'b0;
        end
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {16'h0, v};
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = q32[15:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic sw_wait();
        do begin
            bus(0, 0, OSC_CTRL_ADDR, 16'h0);
        end while (q[0] !== 1'b0);
    endtask
    task automatic por(input logic e, input logic [2:0] s);
        rst_i <= 1'b1; erased_i <= e; isrc <= s;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask
    task automatic cnt(input int n);
        c1 = 0; c2 = 0; c3 = 0;
        repeat (n) begin
            @(posedge clk_i);
            c1 += (cy === 1'b1);
            c2 += (per === 1'b1);
            c3 += (fen === 1'b1);
        end
    endtask
    task automatic close_out();
        if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        failures = 0; compares = 0; seed = 32'd89942;
        rst_i = 1'b1; sys_rst_i = 0; cyc = 0; stb = 0; we = 0; adr = 8'h0;
        dat = 32'h0; erased_i = 0; unlock_i = 0; irq_i = 0; fsafe = 0;
        cfail = 0; ofail = 0; plock = 0; isrc = 3'h2; pm = 2'h0; f = 16'h0;
        pm <= 2'(xs());
        por(0, SRC_PRI);
        chk({13'h0, cur}, 16'h2);
        chk({14'h0, pmo}, {14'h0, pm});
        por(1, SRC_PRI);
        bus(0, 0, OSC_CTRL_ADDR, 0); chk(q, 16'h7700);
        bus(0, 0, CLK_DIV_ADDR, 0); chk(q, 16'h0100);
        bus(0, 0, PLL_FBD_ADDR, 0); chk(q, 16'h0030);
        chk({6'h0, mult}, 16'd50);
        repeat (8) begin
            f = xs() & 16'h01ff;
            d = xs() & 16'hf7df;
            bus(0, 1, PLL_FBD_ADDR, f);
            bus(0, 1, CLK_DIV_ADDR, d);
            bus(0, 0, CLK_DIV_ADDR, 0); chk(q, d);
            chk({6'h0, mult}, f + 16'h2);
            chk({10'h0, pre}, {11'h0, d[4:0]} + 16'h2);
            chk({12'h0, post}, n2(d[7:6]));
        end
        cnt(64); chk(16'(c1), 16'd32); chk(16'(c2), 16'(c1));
        bus(0, 1, CLK_DIV_ADDR, 16'h0800);
        bus(0, 0, CLK_DIV_ADDR, 0); chk(q, 16'h0000);
        bus(0, 1, CLK_DIV_ADDR, 16'h3000);
        bus(0, 1, CLK_DIV_ADDR, 16'hbf00);
        bus(0, 1, CLK_DIV_ADDR, 16'hdf00);
        bus(0, 0, CLK_DIV_ADDR, 0); chk(q, 16'hbf00);
        cnt(512); chk(16'(c2 > 30 && c2 < 34), 16'h1);
        chk(16'(c3), 16'd2);
        irq_i <= 1'b1; @(posedge clk_i); irq_i <= 1'b0; @(posedge clk_i);
        bus(0, 0, CLK_DIV_ADDR, 0); chk(q, 16'hb700);
        bus(1, 1, OSC_CTRL_ADDR, 16'h0001); sw_wait();
        chk(q, 16'h0000); chk({13'h0, cur}, 16'h0);
        chk({15'h0, pll_en}, 16'h0);
        chk({15'h0, gate_low}, 16'h1);
        bus(0, 1, OSC_CTRL_ADDR, 16'h0201);
        bus(0, 0, OSC_CTRL_ADDR, 0); chk(q, 16'h0000);
        bus(1, 1, OSC_CTRL_ADDR, 16'h0400);
        bus(0, 0, OSC_CTRL_ADDR, 0); chk({15'h0, q[10:8] == 3'h4}, 0);
        bus(1, 1, OSC_CTRL_ADDR, 16'h0101); sw_wait();
        repeat (60) @(posedge clk_i);
        bus(0, 0, OSC_CTRL_ADDR, 0); chk(q, 16'h1120);
        chk({15'h0, pll_en}, 16'h1);
        cfail <= 1'b1; @(posedge clk_i); cfail <= 1'b0;
        bus(0, 0, OSC_CTRL_ADDR, 0); chk(q, 16'h1128);
        bus(1, 1, OSC_CTRL_ADDR, 16'h0100);
        bus(0, 0, OSC_CTRL_ADDR, 0); chk(q, 16'h1120);
        sys_rst_i <= 1'b1; repeat (20) @(posedge clk_i); sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        bus(0, 0, PLL_FBD_ADDR, 0); chk(q, f);
        fsafe <= 1'b1;
        bus(1, 1, OSC_CTRL_ADDR, 16'h0180);
        bus(1, 1, OSC_CTRL_ADDR, 16'h0001);
        repeat (20) @(posedge clk_i);
        chk({13'h0, cur}, 16'h1);
        bus(0, 1, PLL_FBD_ADDR, 16'h0);
        bus(0, 0, PLL_FBD_ADDR, 0); chk(q, f);
        ofail <= 1'b1; repeat (10) @(posedge clk_i);
        chk({13'h0, cur}, 16'h4);
        close_out();
    end
endmodule // tb
`default_nettype wire

// ==== verilog/clk_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module clk_ctrl (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sys_rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [2:0] initial_source_cfg_i,
    input wire logic [1:0] primary_mode_cfg_i,
    input wire logic failsafe_switch_cfg_i,
    input wire logic erased_i,
    input wire logic unlock_i,
    input wire logic irq_i,
    input wire logic clock_fail_i,
    input wire logic fast_osc_fail_i,
    input wire logic pll_locked_i,
    output logic [2:0] current_source_sel_o,
    output logic [1:0] primary_mode_o,
    output logic pll_enable_o,
    output logic sys_clk_gate_o,
    output logic cy_en_o,
    output logic per_en_o,
    output logic frc_div_en_o,
    output logic [9:0] pll_mult_o,
    output logic [5:0] pll_pre_o,
    output logic [3:0] pll_post_o
);
    import clk_ctrl_pkg::*;

    // ****************************************
    // helpers
    // ****************************************
    // mask of the doze counter for a ratio code
    function automatic logic [6:0] doze_limit(input logic [2:0] code);
        doze_limit = 7'(({1'b0, 7'h7f}) >> (3'h7 - code));
    endfunction

    // postscaler terminal count, 111 jumps to divide by 256
    function automatic logic [7:0] frc_limit(input logic [2:0] code);
        if (code == 3'h7) begin
            frc_limit = 8'hff;
        end else begin
            frc_limit = 8'(8'h7f >> (3'h7 - code));
        end
    endfunction

    // pll sources use the loop
    function automatic logic uses_pll(input logic [2:0] code);
        uses_pll = (code == SRC_PRI_PLL) || (code == SRC_FRC_PLL);
    endfunction

    // ****************************************
    // state
    // ****************************************
    logic [2:0] cur_src_r, new_src_r;
    logic cfg_lock_r, pin_lock_r, cf_r, sw_req_r;
    logic recover_r, ratio_en_r;
    logic [2:0] doze_r, frc_div_r;
    logic [1:0] post_r;
    logic [4:0] pre_r;
    logic [8:0] fbd_r;
    logic [1:0] prim_r;
    logic unlock_r, ack_r;
    logic [1:0] s1_r, s2_r, s3_r, filt_r;
    sw_state_t sw_state_r;
    logic [2:0] hold_cnt_r;
    logic gate_r;
    logic [5:0] pll_tmr_r;
    logic cy_ph_r, cy_en_r, per_en_r, frc_en_r;
    logic [6:0] doze_cnt_r;
    logic [7:0] frc_cnt_r;
    logic [31:0] rdat_r;

    logic locked, req, wr, wr_osc, wr_div, wr_fbd;
    logic frc_failed, pll_locked, lock_stat, cy_tick;
    logic [2:0] boot_src;

    // ****************************************
    // bus decode
    // ****************************************
    assign req = wb_cyc_i && wb_stb_i && !ack_r;
    assign wr = wb_cyc_i && wb_stb_i && ack_r && wb_we_i; // lands with ack
    assign wr_osc = wr && (wb_adr_i == OSC_CTRL_ADDR) && unlock_r;
    assign wr_div = wr && (wb_adr_i == CLK_DIV_ADDR);
    assign wr_fbd = wr && (wb_adr_i == PLL_FBD_ADDR);
    assign locked = cfg_lock_r && failsafe_switch_cfg_i;
    assign boot_src = erased_i ? ERASED_SRC : initial_source_cfg_i;

    // one wait state, then ack for one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i || sys_rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // read data captured with the request
    always_ff @(posedge clk_i) begin
        if (rst_i || sys_rst_i) begin
            rdat_r <= 32'h0;
        end else if (req) begin
            case (wb_adr_i)
                OSC_CTRL_ADDR: begin
                    rdat_r <= (32'(cur_src_r) << CUR_SRC_LSB)
                        | (32'(new_src_r) << NEW_SRC_LSB)
                        | (32'(cfg_lock_r) << CFG_LOCK_BIT)
                        | (32'(pin_lock_r) << PIN_LOCK_BIT)
                        | (32'(lock_stat) << PLL_LOCK_BIT)
                        | (32'(cf_r) << CF_BIT)
                        | (32'(sw_req_r) << SW_REQ_BIT);
                end
                CLK_DIV_ADDR: begin
                    rdat_r <= (32'(recover_r) << RECOVER_BIT)
                        | (32'(doze_r) << DOZE_LSB)
                        | (32'(ratio_en_r) << RATIO_EN_BIT)
                        | (32'(frc_div_r) << FRC_DIV_LSB)
                        | (32'(post_r) << POST_LSB)
                        | (32'(pre_r) << PRE_LSB);
                end
                PLL_FBD_ADDR: begin
                    rdat_r <= {23'h0, fbd_r};
                end
                default: begin
                    rdat_r <= 32'h0;
                end
            endcase
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

    // unlock arms one oscillator control write
    always_ff @(posedge clk_i) begin
        if (rst_i || sys_rst_i) begin
            unlock_r <= 1'b0;
        end else if (unlock_i) begin
            unlock_r <= 1'b1;
        end else if (wr && (wb_adr_i == OSC_CTRL_ADDR)) begin
            unlock_r <= 1'b0;
        end
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    // three stages; a level counts once stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
            s3_r <= 2'h0;
            filt_r <= 2'h0;
        end else begin
            s1_r <= {pll_locked_i, fast_osc_fail_i};
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < 2; i++) begin
                if (s2_r[i] == s3_r[i]) begin
                    filt_r[i] <= s3_r[i];
                end
            end
        end
    end

    assign frc_failed = filt_r[0];
    assign pll_locked = filt_r[1];

    // ****************************************
    // oscillator control register
    // ****************************************
    // new source and lock bits, power-on only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            new_src_r <= boot_src;
            prim_r <= primary_mode_cfg_i;
            cfg_lock_r <= 1'b0;
            pin_lock_r <= 1'b0;
        end else if (wr_osc) begin
            if (wb_sel_i[1] && !locked
                && wb_dat_i[NEW_SRC_LSB +: 3] != SRC_BACKUP) begin
                new_src_r <= wb_dat_i[NEW_SRC_LSB +: 3];
            end
            if (wb_sel_i[0]) begin
                cfg_lock_r <= locked | wb_dat_i[CFG_LOCK_BIT];
                pin_lock_r <= wb_dat_i[PIN_LOCK_BIT];
            end
        end
    end

    // failure flag: a new failure beats a clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cf_r <= 1'b0;
        end else if (clock_fail_i) begin
            cf_r <= 1'b1;
        end else if (wr_osc && wb_sel_i[0] && !wb_dat_i[CF_BIT]) begin
            cf_r <= 1'b0;
        end
    end

    // switch request, set by software and cleared on completion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sw_req_r <= 1'b0;
        end else if (wr_osc && wb_sel_i[0] && wb_dat_i[SW_REQ_BIT]
                     && !locked) begin
            sw_req_r <= 1'b1;
        end else if (sw_state_r == SW_UNGATE) begin
            sw_req_r <= 1'b0;
        end
    end

    // ****************************************
    // clock switch sequencer
    // ****************************************
    // stop the gate, let the old clock settle, move, reopen
    always_ff @(posedge clk_i) begin
        if (rst_i || sys_rst_i) begin
            sw_state_r <= SW_IDLE;
            hold_cnt_r <= 3'h0;
            gate_r <= 1'b1;
        end else begin
            case (sw_state_r)
                SW_IDLE: begin
                    if (sw_req_r) begin
                        sw_state_r <= SW_GATE;
                        gate_r <= 1'b0;
                        hold_cnt_r <= 3'(HANDOVER_CYC - 1);
                    end
                end
                SW_GATE: begin
                    if (hold_cnt_r == 3'h0) begin
                        sw_state_r <= SW_MOVE;
                    end else begin
                        hold_cnt_r <= hold_cnt_r - 3'h1;
                    end
                end
                SW_MOVE: begin
                    sw_state_r <= SW_UNGATE;
                    gate_r <= 1'b1;
                end
                SW_UNGATE: begin
                    sw_state_r <= SW_IDLE;
                end
                default: begin
                    sw_state_r <= SW_IDLE;
                    gate_r <= 1'b1;
                end
            endcase
        end
    end

    // current source; a failed internal oscillator takes priority
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_src_r <= boot_src;
        end else if (frc_failed) begin
            cur_src_r <= SRC_BACKUP;
        end else if (sw_state_r == SW_MOVE) begin
            cur_src_r <= new_src_r;
        end
    end

    // pll start timer restarts whenever the loop is not in use
    always_ff @(posedge clk_i) begin
        if (rst_i || sys_rst_i || !uses_pll(cur_src_r)) begin
            pll_tmr_r <= 6'h0;
        end else if (pll_tmr_r != 6'(PLL_START_CYC)) begin
            pll_tmr_r <= pll_tmr_r + 6'h1;
        end
    end

    assign lock_stat = uses_pll(cur_src_r)
        && (pll_locked || pll_tmr_r == 6'(PLL_START_CYC));

    // ****************************************
    // clock divisor and feedback registers
    // ****************************************
    // doze controls; an interrupt recovery overrides a write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            recover_r <= 1'b0;
            doze_r <= 3'h0;
            ratio_en_r <= 1'b0;
        end else begin
            if (wr_div && wb_sel_i[1]) begin
                recover_r <= wb_dat_i[RECOVER_BIT];
                if (!ratio_en_r) begin
                    doze_r <= wb_dat_i[DOZE_LSB +: 3];
                end
            end
            if (irq_i && recover_r) begin
                ratio_en_r <= 1'b0;
            end else if (wr_div && wb_sel_i[1]) begin
                // a field written to 000 in the same write also blocks it
                ratio_en_r <= wb_dat_i[RATIO_EN_BIT]
                    && (doze_r != 3'h0)
                    && (ratio_en_r
                        || wb_dat_i[DOZE_LSB +: 3] != 3'h0);
            end
        end
    end

    // postscalers and prescaler; pll fields freeze under the lock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frc_div_r <= FRC_DIV_RST;
            post_r <= 2'h0;
            pre_r <= 5'h0;
        end else if (wr_div) begin
            if (wb_sel_i[1]) begin
                frc_div_r <= wb_dat_i[FRC_DIV_LSB +: 3];
            end
            if (wb_sel_i[0] && !locked) begin
                post_r <= wb_dat_i[POST_LSB +: 2];
                pre_r <= wb_dat_i[PRE_LSB +: 5];
            end
        end
    end

    // feedback divisor, split over two byte lanes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fbd_r <= FBD_RST;
        end else if (wr_fbd && !locked) begin
            if (wb_sel_i[0]) begin
                fbd_r[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                fbd_r[8] <= wb_dat_i[8];
            end
        end
    end

    // ****************************************
    // rate enables
    // ****************************************
    assign cy_tick = cy_ph_r;

    // instruction and peripheral enables
    always_ff @(posedge clk_i) begin
        if (rst_i || sys_rst_i) begin
            cy_ph_r <= 1'b0;
            cy_en_r <= 1'b0;
            per_en_r <= 1'b0;
            doze_cnt_r <= 7'h0;
        end else begin
            cy_ph_r <= !cy_ph_r;
            cy_en_r <= cy_tick;
            per_en_r <= cy_tick
                && (!ratio_en_r || doze_cnt_r == 7'h0);
            if (cy_tick) begin
                if (doze_cnt_r >= doze_limit(doze_r)) begin
                    doze_cnt_r <= 7'h0;
                end else begin
                    doze_cnt_r <= doze_cnt_r + 7'h1;
                end
            end
        end
    end

    // internal oscillator postscaler enable
    always_ff @(posedge clk_i) begin
        if (rst_i || sys_rst_i) begin
            frc_cnt_r <= 8'h0;
            frc_en_r <= 1'b0;
        end else if (frc_cnt_r >= frc_limit(frc_div_r)) begin
            frc_cnt_r <= 8'h0;
            frc_en_r <= 1'b1;
        end else begin
            frc_cnt_r <= frc_cnt_r + 8'h1;
            frc_en_r <= 1'b0;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign current_source_sel_o = cur_src_r;
    assign primary_mode_o = prim_r;
    assign pll_enable_o = uses_pll(cur_src_r);
    assign sys_clk_gate_o = gate_r;
    assign cy_en_o = cy_en_r;
    assign per_en_o = per_en_r;
    assign frc_div_en_o = frc_en_r;
    assign pll_mult_o = {1'b0, fbd_r} + 10'h2;
    assign pll_pre_o = {1'b0, pre_r} + 6'h2;
    assign pll_post_o = {1'b0, post_r, 1'b0} + 4'h2;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || sys_rst_i);

    sequence s_handover;
        (sw_state_r == SW_GATE && !gate_r) [*4] ##1
        (sw_state_r == SW_MOVE && !gate_r) ##1
        (sw_state_r == SW_UNGATE && gate_r);
    endsequence

    property p_handover;
        $rose(sw_state_r == SW_GATE) |-> s_handover;
    endproperty
    a_handover: assert property (p_handover)
        else $error("clock handover sequence broken");

    property p_sw_clear;
        sw_state_r == SW_UNGATE && !wr_osc |=> !sw_req_r;
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("switch request not cleared on completion");

    property p_cy_half;
        cy_en_r |=> !cy_en_r ##1 cy_en_r;
    endproperty
    a_cy_half: assert property (p_cy_half)
        else $error("instruction enable not at half rate");

    property p_no_backup_new;
        new_src_r != SRC_BACKUP;
    endproperty
    a_no_backup_new: assert property (p_no_backup_new)
        else $error("new source holds backup code");

    property p_fail_force;
        frc_failed |=> cur_src_r == SRC_BACKUP;
    endproperty
    a_fail_force: assert property (p_fail_force)
        else $error("failed oscillator did not force backup source");

    property p_cf_set;
        clock_fail_i |=> cf_r;
    endproperty
    a_cf_set: assert property (p_cf_set)
        else $error("clock failure flag lost");

    property p_doze_hold;
        ratio_en_r && wr_div |=> $stable(doze_r);
    endproperty
    a_doze_hold: assert property (p_doze_hold)
        else $error("doze ratio written while enabled");

    property p_zero_no_en;
        doze_r == 3'h0 |-> !ratio_en_r;
    endproperty
    a_zero_no_en: assert property (p_zero_no_en)
        else $error("ratio enabled with zero ratio");

    property p_recover;
        irq_i && recover_r |=> !ratio_en_r;
    endproperty
    a_recover: assert property (p_recover)
        else $error("interrupt did not clear ratio enable");

    property p_lock_ignore;
        locked && !sw_req_r |=> !sw_req_r;
    endproperty
    a_lock_ignore: assert property (p_lock_ignore)
        else $error("switch accepted while locked");

    property p_mult;
        wr_fbd && !locked && wb_sel_i[1:0] == 2'h3
            |=> pll_mult_o == {1'b0, $past(wb_dat_i[8:0])} + 10'h2;
    endproperty
    a_mult: assert property (p_mult)
        else $error("multiplier does not follow feedback field");

    property p_lock_stat;
        !uses_pll(cur_src_r) |-> !lock_stat;
    endproperty
    a_lock_stat: assert property (p_lock_stat)
        else $error("lock status set without pll source");

    property p_per_sub;
        per_en_r |-> cy_en_r;
    endproperty
    a_per_sub: assert property (p_per_sub)
        else $error("peripheral enable off the instruction grid");
endmodule // clk_ctrl
`default_nettype wire
